// ==== core/phase_clock_pkg.sv ====
// constants shared by the interleaved phase clock manager
// Functional notes
// - turnaround high on upper, low on lower
// - each turnaround pulse toggles selected phase
// - pulse sets latch, clock on falling edge
// - phase clock held until driver rises
// - extend discharge until selected driver turns high
// - block turn-on while coil still demagnetising, unless watchdog has set the latch
// - skip cycles while lower clamp engaged
// - force fold-back low during startup
// - watchdog sets zero-current latch after long off
package phase_clock_pkg;
   localparam int unsigned CLK_FREQ_HZ       = 125_000_000;  // mclk rate
   localparam int unsigned WATCHDOG_US       = 200;          // driver-low watchdog, microseconds
   localparam int unsigned WATCHDOG_CYCLES   = (WATCHDOG_US * (CLK_FREQ_HZ / 1_000_000));
   localparam int unsigned WDOG_W            = 16;           // counter width, fits 25000
   localparam logic        PHASE_SEL_RESET   = 1'b0;         // phase a after reset
   localparam int unsigned SYNC_STAGES       = 2;            // synchroniser depth
endpackage

// ==== core/interleaved_phase_clock_manager.sv ====
// interleaved two-phase clock manager: phase alternation, clock latches, discharge hold, skip
`timescale 1ns/1ps
module interleaved_phase_clock_manager
   import phase_clock_pkg::*;
#(
   parameter int unsigned WATCHDOG_LIMIT = WATCHDOG_CYCLES  // shortenable for simulation
)(
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic osc_above_upper,     // timing level above upper threshold
   input  wire logic osc_below_lower,     // timing level below lower threshold
   input  wire logic demag_a_pending,     // phase a coil still demagnetising
   input  wire logic demag_b_pending,     // phase b coil still demagnetising
   input  wire logic driver_a,            // phase a gate driver state
   input  wire logic driver_b,            // phase b gate driver state
   input  wire logic lower_clamp_active,  // error amp at minimum clamp
   input  wire logic startup,             // startup phase in progress
   output logic      turnaround,          // oscillator turnaround pulse
   output logic      discharge_hold,      // keep discharging past lower threshold
   output logic      phase_sel,           // 0 selects phase a, 1 phase b
   output logic      phase_a_clock,       // phase a clock
   output logic      phase_b_clock,       // phase b clock
   output logic      set_pwm_a,           // set request to phase a pwm latch
   output logic      set_pwm_b,           // set request to phase b pwm latch
   output logic      zero_current_latch_a,// phase a zero-current latch
   output logic      zero_current_latch_b,// phase b zero-current latch
   output logic      foldback_force_low   // pull fold-back input down
);

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers: first stage read only by the second
   logic [SYNC_STAGES-1:0] up_s_q;     // upper threshold chain
   logic [SYNC_STAGES-1:0] lo_s_q;     // lower threshold chain
   logic [SYNC_STAGES-1:0] za_s_q;     // demag a chain
   logic [SYNC_STAGES-1:0] zb_s_q;     // demag b chain
   logic [SYNC_STAGES-1:0] da_s_q;     // driver a chain
   logic [SYNC_STAGES-1:0] db_s_q;     // driver b chain
   logic                   up_i;       // synchronised upper
   logic                   lo_i;       // synchronised lower
   logic                   za_i;       // synchronised demag a
   logic                   zb_i;       // synchronised demag b
   logic                   da_i;       // synchronised driver a
   logic                   db_i;       // synchronised driver b

   // two-flop chains for the oscillator, demag and driver levels
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         up_s_q <= '0;
         lo_s_q <= '0;
         za_s_q <= '0;
         zb_s_q <= '0;
         da_s_q <= '0;
         db_s_q <= '0;
      end
      else
      begin
         up_s_q <= {up_s_q[0], osc_above_upper};
         lo_s_q <= {lo_s_q[0], osc_below_lower};
         za_s_q <= {za_s_q[0], demag_a_pending};
         zb_s_q <= {zb_s_q[0], demag_b_pending};
         da_s_q <= {da_s_q[0], driver_a};
         db_s_q <= {db_s_q[0], driver_b};
      end
   end

   assign up_i = up_s_q[SYNC_STAGES-1];
   assign lo_i = lo_s_q[SYNC_STAGES-1];
   assign za_i = za_s_q[SYNC_STAGES-1];
   assign zb_i = zb_s_q[SYNC_STAGES-1];
   assign da_i = da_s_q[SYNC_STAGES-1];
   assign db_i = db_s_q[SYNC_STAGES-1];

   ////////////////////////////////////////////////////////////////////////////
   // turnaround comparator with hysteresis
   logic turn_q;    // turnaround pulse state
   logic turn_d;    // next turnaround state
   logic turn_dly_q;// previous turnaround for edges
   logic da_dly_q;  // previous driver a
   logic db_dly_q;  // previous driver b
   logic turn_rise; // turnaround rising edge
   logic turn_fall; // turnaround falling edge
   logic da_rise;   // driver a turned on
   logic db_rise;   // driver b turned on
   logic sel_drv;   // selected driver level

   assign sel_drv = phase_sel ? db_i : da_i;

   // charge ends at upper; discharge ends below lower, held while selected
   // driver is still off so the branches stay half a period apart
   always_comb
   begin
      turn_d = turn_q;
      if (!turn_q && up_i)
         turn_d = 1'b1;
      else if (turn_q && lo_i && !discharge_hold)
         turn_d = 1'b0;
   end

   // hold only when the pending clock of the served phase is unanswered
   assign discharge_hold = lo_i && (phase_sel ? phase_b_clock : phase_a_clock)
                           && !sel_drv;

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         turn_q     <= 1'b0;
         turn_dly_q <= 1'b0;
         da_dly_q   <= 1'b0;
         db_dly_q   <= 1'b0;
      end
      else
      begin
         turn_q     <= turn_d;
         turn_dly_q <= turn_q;
         da_dly_q   <= da_i;
         db_dly_q   <= db_i;
      end
   end

   assign turnaround = turn_q;
   assign turn_rise  = turn_q && !turn_dly_q;
   assign turn_fall  = !turn_q && turn_dly_q;
   assign da_rise    = da_i && !da_dly_q;
   assign db_rise    = db_i && !db_dly_q;

   ////////////////////////////////////////////////////////////////////////////
   // divide-by-two phase selector, first pulse serves phase a
   logic sel_q; // phase currently served
   logic arm_a_q; // latch set by turnaround, awaiting falling edge
   logic arm_b_q;

   // selector advances after each pulse's falling edge so the pulse
   // and its clock belong to the same phase
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         sel_q <= PHASE_SEL_RESET;
      else if (turn_fall)
         sel_q <= ~sel_q;
   end

   assign phase_sel = sel_q;

   // clock latches: set by pulse, clock appears on falling edge,
   // cleared by the driver's rising edge; set wins over clear
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         arm_a_q       <= 1'b0;
         arm_b_q       <= 1'b0;
         phase_a_clock <= 1'b0;
         phase_b_clock <= 1'b0;
      end
      else
      begin
         if (turn_rise && !sel_q && !lower_clamp_active)
            arm_a_q <= 1'b1;
         else if (turn_fall)
            arm_a_q <= 1'b0;
         if (turn_rise && sel_q && !lower_clamp_active)
            arm_b_q <= 1'b1;
         else if (turn_fall)
            arm_b_q <= 1'b0;
         if (turn_fall && arm_a_q)
            phase_a_clock <= 1'b1;
         else if (da_rise)
            phase_a_clock <= 1'b0;
         if (turn_fall && arm_b_q)
            phase_b_clock <= 1'b1;
         else if (db_rise)
            phase_b_clock <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // zero-current latches with off-time watchdog
   logic [WDOG_W-1:0] wd_a_q; // driver a off-time count
   logic [WDOG_W-1:0] wd_b_q; // driver b off-time count
   logic              wd_a_hit;
   logic              wd_b_hit;

   assign wd_a_hit = (wd_a_q >= WDOG_W'(WATCHDOG_LIMIT));
   assign wd_b_hit = (wd_b_q >= WDOG_W'(WATCHDOG_LIMIT));

   // counts saturate so a long idle cannot wrap back below the limit
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wd_a_q <= '0;
         wd_b_q <= '0;
      end
      else
      begin
         if (da_i)
            wd_a_q <= '0;
         else if (!wd_a_hit)
            wd_a_q <= wd_a_q + WDOG_W'(1);
         if (db_i)
            wd_b_q <= '0;
         else if (!wd_b_hit)
            wd_b_q <= wd_b_q + WDOG_W'(1);
      end
   end

   // latch sets on core reset or watchdog, clears when driver turns on;
   // either set needs the driver off: the watchdog count is still saturated
   // on the turn-on cycle and would otherwise keep the latch set for good
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         zero_current_latch_a <= 1'b0;
         zero_current_latch_b <= 1'b0;
      end
      else
      begin
         if ((!za_i || wd_a_hit) && !da_i)
            zero_current_latch_a <= 1'b1;
         else if (da_rise)
            zero_current_latch_a <= 1'b0;
         if ((!zb_i || wd_b_hit) && !db_i)
            zero_current_latch_b <= 1'b1;
         else if (db_rise)
            zero_current_latch_b <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pwm set gating: no turn-on into a demagnetising coil unless the watchdog has set the latch
   assign set_pwm_a = phase_a_clock && zero_current_latch_a && !lower_clamp_active;
   assign set_pwm_b = phase_b_clock && zero_current_latch_b && !lower_clamp_active;

   // fold-back disabled for the whole startup period
   assign foldback_force_low = startup;

endmodule

// ==== test/pcm_chk_assertions.sv ====
// checker: port timing of the phase clock manager
`timescale 1ns/1ps
module pcm_chk (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic osc_above_upper,
   input wire logic osc_below_lower,
   input wire logic driver_a,
   input wire logic lower_clamp_active,
   input wire logic startup,
   input wire logic turnaround,
   input wire logic discharge_hold,
   input wire logic phase_sel,
   input wire logic phase_a_clock,
   input wire logic set_pwm_a,
   input wire logic set_pwm_b,
   input wire logic zero_current_latch_a,
   input wire logic foldback_force_low
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // inputs reach the logic two flops late, hence the past depths
   property p_fold; foldback_force_low == startup; endproperty
   a_fold: assert property (p_fold) else $error("fold-back force wrong");
   property p_turn; $rose(turnaround) |-> $past(osc_above_upper, 3); endproperty
   a_turn: assert property (p_turn) else $error("turnaround rose early");
   property p_sel; $fell(turnaround) |=> phase_sel != $past(phase_sel); endproperty
   a_sel: assert property (p_sel) else $error("selector did not toggle");
   property p_clk;
      $rose(phase_a_clock) |-> !$past(turnaround) && $past(turnaround, 2) && !$past(phase_sel);
   endproperty
   a_clk: assert property (p_clk) else $error("phase a clock off pulse edge");
   property p_hold; (phase_a_clock && !driver_a) [*4] |=> phase_a_clock; endproperty
   a_hold: assert property (p_hold) else $error("phase a clock dropped early");
   property p_dis; discharge_hold |-> $past(osc_below_lower, 2); endproperty
   a_dis: assert property (p_dis) else $error("hold without lower level");
   property p_gate; set_pwm_a |-> phase_a_clock && zero_current_latch_a; endproperty
   a_gate: assert property (p_gate) else $error("set without clock and latch");
   property p_skip; lower_clamp_active [*3] |-> !set_pwm_a && !set_pwm_b; endproperty
   a_skip: assert property (p_skip) else $error("set during clamp");
   c_hold: cover property (discharge_hold);
   c_skip: cover property (lower_clamp_active && turnaround);
   c_b: cover property ($rose(set_pwm_b));
endmodule
bind interleaved_phase_clock_manager pcm_chk i_chk (
   .mclk                 (mclk),
   .reset_n              (reset_n),
   .osc_above_upper      (osc_above_upper),
   .osc_below_lower      (osc_below_lower),
   .driver_a             (driver_a),
   .lower_clamp_active   (lower_clamp_active),
   .startup              (startup),
   .turnaround           (turnaround),
   .discharge_hold       (discharge_hold),
   .phase_sel            (phase_sel),
   .phase_a_clock        (phase_a_clock),
   .set_pwm_a            (set_pwm_a),
   .set_pwm_b            (set_pwm_b),
   .zero_current_latch_a (zero_current_latch_a),
   .foldback_force_low   (foldback_force_low)
);

// ==== test/pcm_far_model.sv ====
// far side: oscillator comparator, drivers, zero-current detectors
`timescale 1ns/1ps
module pcm_far_model (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       turnaround,
   input  wire logic [1:0] set_pwm,
   input  wire logic       slow,  // long demagnetisation
   input  wire logic       stuck, // detector never reports core reset
   output logic            upper,
   output logic            lower,
   output logic      [1:0] drv,
   output logic      [1:0] demag
);
   logic [5:0] ramp_q;     // timing level
   logic [6:0] cnt_q [2];  // on time, then demag time
   // ramp charges while turnaround low and discharges while high
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         ramp_q <= 6'h00;
      else if (turnaround)
         ramp_q <= (ramp_q != 6'h00) ? ramp_q - 6'h01 : 6'h00;
      else if (ramp_q < 6'h14)
         ramp_q <= ramp_q + 6'h01;
   end
   assign upper = !turnaround && ramp_q == 6'h14;
   assign lower = turnaround && ramp_q == 6'h00;
   for (genvar i = 0; i < 2; i++)
   begin : g_ph
      // driver turns on at once when set, whatever the coil says
      always_ff @(posedge mclk or negedge reset_n)
      begin
         if (!reset_n)
         begin
            drv[i] <= 1'b0;
            cnt_q[i] <= 7'h00;
         end
         else if (drv[i])
         begin
            drv[i] <= cnt_q[i] != 7'h00;
            cnt_q[i] <= (cnt_q[i] != 7'h00) ? cnt_q[i] - 7'h01 : (slow ? 7'h64 : 7'h04);
         end
         else if (set_pwm[i])
         begin
            drv[i] <= 1'b1;
            cnt_q[i] <= 7'h08;
         end
         else if (cnt_q[i] != 7'h00)
            cnt_q[i] <= cnt_q[i] - 7'h01;
      end
      assign demag[i] = stuck || (!drv[i] && cnt_q[i] != 7'h00);
   end
endmodule

// ==== test/interleaved_phase_clock_manager_tb.sv ====
// testbench: phase clock manager against the far-side model
`timescale 1ns/1ps
module interleaved_phase_clock_manager_tb;
   localparam int LIM = 120;  // shortened watchdog
   logic mclk, reset_n, clamp, startup, slow, stuck;
   logic upper, lower, ta, hold, sel, clk_a, clk_b, zl_a, zl_b, fold;
   logic [1:0] pwm, drv, dm;
   int num_errors, samples_checked, cycles;
   interleaved_phase_clock_manager #(.WATCHDOG_LIMIT(LIM)) i_dut (
      .mclk(mclk), .reset_n(reset_n), .osc_above_upper(upper), .osc_below_lower(lower),
      .demag_a_pending(dm[0]), .demag_b_pending(dm[1]), .driver_a(drv[0]), .driver_b(drv[1]),
      .lower_clamp_active(clamp), .startup(startup), .turnaround(ta), .discharge_hold(hold),
      .phase_sel(sel), .phase_a_clock(clk_a), .phase_b_clock(clk_b), .set_pwm_a(pwm[0]),
      .set_pwm_b(pwm[1]), .zero_current_latch_a(zl_a), .zero_current_latch_b(zl_b),
      .foldback_force_low(fold));
   pcm_far_model i_far (.mclk(mclk), .reset_n(reset_n), .turnaround(ta), .set_pwm(pwm),
      .slow(slow), .stuck(stuck), .upper(upper), .lower(lower), .drv(drv), .demag(dm));
   task automatic check(input string name, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // count driver a turn-ons, hold cycles and turn-ons while demagnetising
   task automatic watch(input int n, output int rises, holds, bad);
      logic pd, pm;
      rises = 0;
      holds = 0;
      bad = 0;
      repeat (n)
      begin
         pd = drv[0];
         pm = dm[0];
         @(posedge mclk);
         #1;
         rises += int'(drv[0] && !pd);
         bad += int'(drv[0] && !pd && pm);
         holds += int'(hold === 1'b1);
      end
   endtask
   task automatic t_alt();
      logic [1:0] exp;
      int k;
      exp = 2'b01;
      repeat (4)
      begin
         for (k = 0; k < 300 && !(clk_a || clk_b); k++)
            @(posedge mclk) #1;
         check("clock", {clk_b, clk_a}, exp);
         check("selector", sel, exp[0]);
         for (k = 0; k < 300 && (clk_a || clk_b); k++)
            @(posedge mclk) #1;
         check("clock_clear", {clk_b, clk_a}, 2'b00);
         exp = {exp[0], exp[1]};
      end
   endtask
   task automatic t_slow();
      int r, h, b;
      @(posedge mclk);
      slow <= 1'b1;
      #1;
      watch(1000, r, h, b);
      check("hold_seen", h != 0, 1'b1);
      check("early_on", b, 0);
      @(posedge mclk);
      slow <= 1'b0;
      #1;
   endtask
   task automatic t_skip();
      int r, h, b;
      @(posedge mclk);
      clamp <= 1'b1;
      #1;
      watch(20, r, h, b);
      watch(300, r, h, b);
      check("skip_on", r, 0);
      @(posedge mclk);
      clamp <= 1'b0;
      #1;
      watch(300, r, h, b);
      check("resume", r != 0, 1'b1);
   endtask
   task automatic t_wdog();
      int r, h, b, n;
      @(posedge mclk);
      stuck <= 1'b1;
      #1;
      watch(400, r, h, b);
      for (n = 0; n < 600 && drv[0] !== 1'b1; n++)
         @(posedge mclk) #1;
      for (n = 0; n < 600 && drv[0] !== 1'b0; n++)
         @(posedge mclk) #1;
      for (n = 0; n < 400 && zl_a !== 1'b1; n++)
         @(posedge mclk) #1;
      check("wdog_time", n >= LIM - 1 && n <= LIM + 6, 1'b1);
      @(posedge mclk);
      stuck <= 1'b0;
      #1;
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         num_errors++;
         summarize();
      end
   end
   initial
   begin
      {reset_n, clamp, startup, slow, stuck} = 5'h00;
      {num_errors, samples_checked, cycles} = '0;
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      #1;
      check("reset", {zl_b, zl_a, hold, ta, sel, clk_b, clk_a}, 7'h00);
      t_alt();
      @(posedge mclk);
      startup <= 1'b1;
      @(posedge mclk) #1;
      check("fold", fold, 1'b1);
      @(posedge mclk);
      startup <= 1'b0;
      #1;
      check("fold_off", fold, 1'b0);
      t_slow();
      t_skip();
      t_wdog();
      summarize();
   end
endmodule
